// ==== hdl/pwrax_regs.sv ====
// power-control auxiliary register bank with APB slave
// assumes NRST is the core power-on reset; SYSTEM_RESET and power states are async levels
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module pwrax_regs
    import pwrax_pkg::*;
#(
    parameter int SLOW_OSC_DELAY_STEP = 1
) (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [DATA_W-1:0] PWDATA,
    output logic [DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RUN_MODE,
    input wire logic DEEP_SLEEP,
    input wire logic POWER_DOWN,
    input wire logic SYSTEM_RESET,
    input wire logic [1:0] BROWNOUT_CTRL,
    output logic [2:0] SLOW_OSC_START_DELAY,
    output logic SLOW_OSC_REQ,
    output logic FAST_OSC_TRIM_SELECT,
    output logic FAST_OSC_POWER_OWNER,
    output logic [1:0] BROWNOUT_SELECT_FIELD,
    output logic FLASH_DEEP_STANDBY,
    output logic FLASH_FAST_WAKE,
    output logic SLEEP_CORE_LEVEL_LOW
);

    localparam int CNT_W = 16;

    if (SLOW_OSC_DELAY_STEP < 1 || SLOW_OSC_DELAY_STEP * 7 >= (1 << CNT_W)) begin : g_bad_step
        $error("SLOW_OSC_DELAY_STEP out of range");
    end

    // ----------------------------------------------------------------
    // synchronised inputs
    // ----------------------------------------------------------------
    logic [5:0] async_vec;
    logic [5:0] sync_vec;
    logic run_s;
    logic sleep_s;
    logic pdown_s;
    logic sys_rst;
    logic [1:0] brownout_s;

    assign async_vec = {BROWNOUT_CTRL, SYSTEM_RESET, POWER_DOWN, DEEP_SLEEP, RUN_MODE};

    pwrax_sync #(
        .WIDTH(6)
    ) u_sync (
        .clk(SYS_CLK),
        .rst_n(NRST),
        .async_in(async_vec),
        .sync_out(sync_vec)
    );

    assign run_s = sync_vec[0];
    assign sleep_s = sync_vec[1];
    assign pdown_s = sync_vec[2];
    assign sys_rst = sync_vec[3];
    assign brownout_s = sync_vec[5:4];

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [2:0] delay_reg;
    logic brownout_src_reg;
    logic policy_reg;
    logic trim_reg;
    logic owner_reg;
    logic standby_reg;
    logic wake_reg;
    logic [1:0] level_reg;
    logic [1:0] level_en_reg;
    logic unlocked;

    // ----------------------------------------------------------------
    // APB handshake: one wait state, writes land on the completing edge
    // ----------------------------------------------------------------
    logic acc_first;
    logic done;
    logic wr_fire;
    logic key_write;
    logic flash_accept;
    logic [DATA_W-1:0] rd_value;

    assign acc_first = PSEL && PENABLE && !PREADY;
    assign done = PSEL && PENABLE && PREADY;
    assign wr_fire = done && PWRITE;
    assign key_write = wr_fire && (PADDR == OFF_FLASH_CTL) && (PWDATA == FLASH_UNLOCK_KEY);
    // the key word itself never lands in the register
    assign flash_accept = wr_fire && (PADDR == OFF_FLASH_CTL) && unlocked &&
                          (PWDATA != FLASH_UNLOCK_KEY);

    pwrax_key_gate u_key (
        .clk(SYS_CLK),
        .rst_n(NRST),
        .clear(sys_rst),
        .done(done),
        .key_write(key_write),
        .unlocked(unlocked)
    );

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= acc_first;
        end
    end

    // unmapped addresses answer with an error and read zero
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            PSLVERR <= 1'b0;
        end else if (acc_first) begin
            PSLVERR <= !pwrax_is_mapped(PADDR);
        end else begin
            PSLVERR <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // read mux; reserved bits return their reset pattern
    // ----------------------------------------------------------------
    always_comb begin
        rd_value = '0;
        unique case (PADDR)
            OFF_OSC_CFG: begin
                rd_value = RST_OSC_CFG;
                rd_value[OSC_DELAY_MSB:OSC_DELAY_LSB] = delay_reg;
                rd_value[OSC_BROWNOUT_SRC_BIT] = brownout_src_reg;
                rd_value[OSC_POLICY_BIT] = policy_reg;
                rd_value[OSC_TRIM_BIT] = trim_reg;
                rd_value[OSC_OWNER_BIT] = owner_reg;
            end
            OFF_FLASH_CTL: begin
                rd_value = RST_FLASH_CTL;
                rd_value[FLASH_RUN_BIT] = run_s;
                rd_value[FLASH_STANDBY_BIT] = standby_reg;
                rd_value[FLASH_WAKE_BIT] = wake_reg;
            end
            OFF_SLP_LEVEL: begin
                rd_value = RST_SLP_LEVEL;
                rd_value[LEVEL_MSB:LEVEL_LSB] = level_reg;
            end
            OFF_SLP_ENABLE: begin
                rd_value = RST_SLP_ENABLE;
                rd_value[LEVEL_MSB:LEVEL_LSB] = level_en_reg;
            end
            default: begin
                rd_value = '0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            PRDATA <= '0;
        end else if (acc_first && !PWRITE) begin
            PRDATA <= rd_value;
        end else begin
            PRDATA <= '0;
        end
    end

    // ----------------------------------------------------------------
    // oscillator configuration, system-reset fields and power-on-reset trim select
    // ----------------------------------------------------------------
    // writes ignore reserved positions; software is expected to keep them
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            delay_reg <= RST_OSC_CFG[OSC_DELAY_MSB:OSC_DELAY_LSB];
            brownout_src_reg <= RST_OSC_CFG[OSC_BROWNOUT_SRC_BIT];
            policy_reg <= RST_OSC_CFG[OSC_POLICY_BIT];
            owner_reg <= RST_OSC_CFG[OSC_OWNER_BIT];
        end else if (sys_rst) begin
            delay_reg <= RST_OSC_CFG[OSC_DELAY_MSB:OSC_DELAY_LSB];
            brownout_src_reg <= RST_OSC_CFG[OSC_BROWNOUT_SRC_BIT];
            policy_reg <= RST_OSC_CFG[OSC_POLICY_BIT];
            owner_reg <= RST_OSC_CFG[OSC_OWNER_BIT];
        end else if (wr_fire && PADDR == OFF_OSC_CFG) begin
            delay_reg <= PWDATA[OSC_DELAY_MSB:OSC_DELAY_LSB];
            brownout_src_reg <= PWDATA[OSC_BROWNOUT_SRC_BIT];
            policy_reg <= PWDATA[OSC_POLICY_BIT];
            owner_reg <= PWDATA[OSC_OWNER_BIT];
        end
    end

    // trim select survives system reset; only power-on reset restores it
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            trim_reg <= RST_OSC_CFG[OSC_TRIM_BIT];
        end else if (wr_fire && PADDR == OFF_OSC_CFG &&
                     (owner_reg || PWDATA[OSC_OWNER_BIT])) begin
            trim_reg <= PWDATA[OSC_TRIM_BIT];
        end
    end

    // ----------------------------------------------------------------
    // flash standby control
    // ----------------------------------------------------------------
    // hardware clear wins: software cannot hold standby through a sleep entry
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            standby_reg <= RST_FLASH_CTL[FLASH_STANDBY_BIT];
        end else if (sys_rst || sleep_s || pdown_s) begin
            standby_reg <= 1'b0;
        end else if (flash_accept) begin
            standby_reg <= PWDATA[FLASH_STANDBY_BIT];
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            wake_reg <= RST_FLASH_CTL[FLASH_WAKE_BIT];
        end else if (sys_rst) begin
            wake_reg <= RST_FLASH_CTL[FLASH_WAKE_BIT];
        end else if (flash_accept) begin
            wake_reg <= PWDATA[FLASH_WAKE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // deep-sleep core level, power-on reset only
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            level_reg <= RST_SLP_LEVEL[LEVEL_MSB:LEVEL_LSB];
        end else if (wr_fire && PADDR == OFF_SLP_LEVEL) begin
            level_reg <= PWDATA[LEVEL_MSB:LEVEL_LSB];
        end
    end

    // level select is written regardless of the enable; software orders it
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            level_en_reg <= RST_SLP_ENABLE[LEVEL_MSB:LEVEL_LSB];
        end else if (wr_fire && PADDR == OFF_SLP_ENABLE) begin
            level_en_reg <= PWDATA[LEVEL_MSB:LEVEL_LSB];
        end
    end

    // unused and reserved codes fall back to the safe higher level
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            SLEEP_CORE_LEVEL_LOW <= 1'b0;
        end else begin
            SLEEP_CORE_LEVEL_LOW <= (level_en_reg == LEVEL_EN_FOLLOW) &&
                                    (level_reg == LEVEL_1V2);
        end
    end

    // ----------------------------------------------------------------
    // slow oscillator request sequencing
    // ----------------------------------------------------------------
    pwrax_osc_state_t osc_state_reg;
    pwrax_osc_state_t osc_state_next;
    logic [CNT_W-1:0] delay_cnt_reg;
    logic [CNT_W-1:0] delay_load;

    assign delay_load = CNT_W'(delay_reg) * CNT_W'(SLOW_OSC_DELAY_STEP);

    always_comb begin
        osc_state_next = osc_state_reg;
        unique case (osc_state_reg)
            OSC_AWAKE: begin
                if (sleep_s && policy_reg) begin
                    osc_state_next = OSC_ASLEEP;
                end
            end
            OSC_ASLEEP: begin
                if (!policy_reg) begin
                    osc_state_next = OSC_AWAKE;
                end else if (!sleep_s) begin
                    osc_state_next = OSC_STARTING;
                end
            end
            OSC_STARTING: begin
                if (sleep_s && policy_reg) begin
                    osc_state_next = OSC_ASLEEP;
                end else if (delay_cnt_reg == '0 || !policy_reg) begin
                    osc_state_next = OSC_AWAKE;
                end
            end
            default: begin
                osc_state_next = OSC_AWAKE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            osc_state_reg <= OSC_AWAKE;
        end else if (sys_rst) begin
            osc_state_reg <= OSC_AWAKE;
        end else begin
            osc_state_reg <= osc_state_next;
        end
    end

    // the count is loaded while asleep, so a late field change still counts
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            delay_cnt_reg <= '0;
        end else if (osc_state_reg == OSC_ASLEEP) begin
            delay_cnt_reg <= delay_load;
        end else if (osc_state_reg == OSC_STARTING && delay_cnt_reg != '0) begin
            delay_cnt_reg <= delay_cnt_reg - CNT_W'(1);
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            SLOW_OSC_REQ <= 1'b1;
        end else if (sys_rst) begin
            SLOW_OSC_REQ <= 1'b1;
        end else begin
            SLOW_OSC_REQ <= (osc_state_next == OSC_AWAKE);
        end
    end

    // ----------------------------------------------------------------
    // configuration outputs
    // ----------------------------------------------------------------
    assign SLOW_OSC_START_DELAY = delay_reg;
    assign FAST_OSC_TRIM_SELECT = trim_reg;
    assign FAST_OSC_POWER_OWNER = owner_reg;
    assign FLASH_DEEP_STANDBY = standby_reg;

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            BROWNOUT_SELECT_FIELD <= BROWNOUT_FORCED;
        end else if (brownout_src_reg) begin
            BROWNOUT_SELECT_FIELD <= brownout_s;
        end else begin
            BROWNOUT_SELECT_FIELD <= BROWNOUT_FORCED;
        end
    end

    // wake choice frozen while asleep so the exit sees one stable value
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            FLASH_FAST_WAKE <= RST_FLASH_CTL[FLASH_WAKE_BIT];
        end else if (!sleep_s) begin
            FLASH_FAST_WAKE <= wake_reg;
        end
    end

endmodule : pwrax_regs
`default_nettype wire

// ==== common/pwrax_pkg.sv ====
// constants, types and decode helpers for the power-control auxiliary registers
// assumes a 32-bit APB slave with 8-bit byte addresses and one 10 MHz clock

package pwrax_pkg;

    // ----------------------------------------------------------------
    // bus geometry and register offsets
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFF_OSC_CFG = 8'h14;
    localparam logic [7:0] OFF_FLASH_CTL = 8'h20;
    localparam logic [7:0] OFF_SLP_LEVEL = 8'h24;
    localparam logic [7:0] OFF_SLP_ENABLE = 8'h28;

    // ----------------------------------------------------------------
    // reset values and unlock key
    // ----------------------------------------------------------------
    localparam logic [31:0] RST_OSC_CFG = 32'h00000EAF;
    localparam logic [31:0] RST_FLASH_CTL = 32'h00000000;
    localparam logic [31:0] RST_SLP_LEVEL = 32'h00000004;
    localparam logic [31:0] RST_SLP_ENABLE = 32'h00000000;
    localparam logic [31:0] FLASH_UNLOCK_KEY = 32'h01753603;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int OSC_DELAY_LSB = 10;
    localparam int OSC_DELAY_MSB = 12;
    localparam int OSC_BROWNOUT_SRC_BIT = 9;
    localparam int OSC_POLICY_BIT = 7;
    localparam int OSC_TRIM_BIT = 6;
    localparam int OSC_OWNER_BIT = 5;
    localparam int FLASH_RUN_BIT = 2;
    localparam int FLASH_STANDBY_BIT = 1;
    localparam int FLASH_WAKE_BIT = 0;
    localparam int LEVEL_LSB = 2;
    localparam int LEVEL_MSB = 3;

    // ----------------------------------------------------------------
    // field encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] LEVEL_1V5 = 2'h1;
    localparam logic [1:0] LEVEL_1V2 = 2'h3;
    localparam logic [1:0] LEVEL_EN_FIXED = 2'h0;
    localparam logic [1:0] LEVEL_EN_FOLLOW = 2'h3;
    localparam logic [1:0] BROWNOUT_FORCED = 2'h3;

    // ----------------------------------------------------------------
    // slow oscillator request states, gray along awake-asleep-starting
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OSC_AWAKE = 2'h0,
        OSC_ASLEEP = 2'h1,
        OSC_STARTING = 2'h3
    } pwrax_osc_state_t;

    function automatic logic pwrax_is_mapped(input logic [7:0] addr);
        return (addr == OFF_OSC_CFG) || (addr == OFF_FLASH_CTL) ||
               (addr == OFF_SLP_LEVEL) || (addr == OFF_SLP_ENABLE);
    endfunction : pwrax_is_mapped

endpackage : pwrax_pkg

// ==== hdl/pwrax_sync.sv ====
// two-flop synchroniser for a vector of independent levels
// assumes each bit is a quasi-static level; multi-bit codes may skew by one clock
`timescale 1ns/1ps
`default_nettype none

module pwrax_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    if (WIDTH < 1) begin : g_bad_width
        $error("pwrax_sync needs at least one bit");
    end

    // ----------------------------------------------------------------
    // first stage feeds only the second
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : pwrax_sync
`default_nettype wire

// ==== hdl/pwrax_key_gate.sv ====
// unlock tracker for the key-protected flash control register
// assumes done marks the completing edge of every bus transfer
`timescale 1ns/1ps
`default_nettype none

module pwrax_key_gate (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic done,
    input wire logic key_write,
    output logic unlocked
);

    // ----------------------------------------------------------------
    // arm on a key write, drop on any other completed transfer
    // ----------------------------------------------------------------
    // a read in between also relocks: the key must immediately precede
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unlocked <= 1'b0;
        end else if (clear) begin
            unlocked <= 1'b0;
        end else if (done) begin
            unlocked <= key_write;
        end
    end

endmodule : pwrax_key_gate
`default_nettype wire

// ==== testbench/pwrax_regs_monitor.sv ====
// assertion checker for the power-control auxiliary register bank
// assumes it sees only the bank's ports; bound in by the bind at the foot
`timescale 1ns/1ps
`default_nettype none

module pwrax_regs_monitor import pwrax_pkg::*; (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [DATA_W-1:0] PWDATA,
    input wire logic [DATA_W-1:0] PRDATA,
    input wire logic PREADY,
    input wire logic RUN_MODE,
    input wire logic DEEP_SLEEP,
    input wire logic SYSTEM_RESET,
    input wire logic [2:0] SLOW_OSC_START_DELAY,
    input wire logic SLOW_OSC_REQ,
    input wire logic FAST_OSC_TRIM_SELECT,
    input wire logic FAST_OSC_POWER_OWNER,
    input wire logic [1:0] BROWNOUT_SELECT_FIELD,
    input wire logic FLASH_DEEP_STANDBY,
    input wire logic SLEEP_CORE_LEVEL_LOW
);
    // ----------------------------------------------------------------
    // shadow of the write-only-visible fields
    // ----------------------------------------------------------------
    logic wr;
    logic low_exp;
    logic src_reg;
    logic [2:0] dly_reg;
    logic [1:0] lvl_reg;
    logic [1:0] en_reg;
    assign wr = PSEL && PENABLE && PREADY && PWRITE;
    assign low_exp = (lvl_reg == 2'h3) && (en_reg == 2'h3);

    // system reset snaps the shadow early, so checks just pause meanwhile
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            dly_reg <= 3'h3;
            src_reg <= 1'h1;
        end else if (SYSTEM_RESET) begin
            dly_reg <= 3'h3;
            src_reg <= 1'h1;
        end else if (wr && PADDR == OFF_OSC_CFG) begin
            dly_reg <= PWDATA[12:10];
            src_reg <= PWDATA[9];
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            lvl_reg <= 2'h1;
            en_reg <= 2'h0;
        end else begin
            if (wr && PADDR == OFF_SLP_LEVEL) lvl_reg <= PWDATA[3:2];
            if (wr && PADDR == OFF_SLP_ENABLE) en_reg <= PWDATA[3:2];
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    a_standby_sleep_clr: assert property (DEEP_SLEEP [*5] |-> !FLASH_DEEP_STANDBY)
        else $error("flash standby held during deep sleep");
    a_req_drop_cause: assert property ($fell(SLOW_OSC_REQ) |-> $past(DEEP_SLEEP, 2))
        else $error("slow osc request dropped outside deep sleep");
    a_brownout_forced: assert property ((!src_reg) [*3] |-> BROWNOUT_SELECT_FIELD == 2'h3)
        else $error("brownout selection not forced");
    a_core_level_map: assert property (SLEEP_CORE_LEVEL_LOW == $past(low_exp))
        else $error("sleep core level mismatch");
    a_delay_follow: assert property ((!SYSTEM_RESET && $stable(dly_reg)) [*3] |->
        SLOW_OSC_START_DELAY == dly_reg) else $error("start delay mismatch");
    a_run_flag_read: assert property (PREADY && !PWRITE && PADDR == OFF_FLASH_CTL &&
        RUN_MODE == $past(RUN_MODE, 4) |-> PRDATA[2] == RUN_MODE) else $error("run flag wrong");
    a_trim_change_src: assert property ($changed(FAST_OSC_TRIM_SELECT) |->
        $past(PREADY) || $past(PREADY, 2)) else $error("trim changed without a write");
    a_trim_owner: assert property ($rose(FAST_OSC_TRIM_SELECT) |-> FAST_OSC_POWER_OWNER)
        else $error("trim set without owner bit");
endmodule : pwrax_regs_monitor

bind pwrax_regs pwrax_regs_monitor u_mon (.SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .RUN_MODE(RUN_MODE), .DEEP_SLEEP(DEEP_SLEEP), .SYSTEM_RESET(SYSTEM_RESET),
    .SLOW_OSC_START_DELAY(SLOW_OSC_START_DELAY), .SLOW_OSC_REQ(SLOW_OSC_REQ),
    .FAST_OSC_TRIM_SELECT(FAST_OSC_TRIM_SELECT), .FAST_OSC_POWER_OWNER(FAST_OSC_POWER_OWNER),
    .BROWNOUT_SELECT_FIELD(BROWNOUT_SELECT_FIELD), .FLASH_DEEP_STANDBY(FLASH_DEEP_STANDBY),
    .SLEEP_CORE_LEVEL_LOW(SLEEP_CORE_LEVEL_LOW));

`default_nettype wire

// ==== testbench/test_pwrax_regs.sv ====
// self-checking bench for the power-control auxiliary register bank
// assumes pwrax_pkg and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none

module test_pwrax_regs import pwrax_pkg::*;;
    typedef struct {
        logic k;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] r;
        logic e;
    } pwrax_row_t;
    logic SYS_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
    logic RUN_MODE, DEEP_SLEEP, POWER_DOWN, SYSTEM_RESET, SLOW_OSC_REQ;
    logic FAST_OSC_TRIM_SELECT, FAST_OSC_POWER_OWNER, FLASH_DEEP_STANDBY, FLASH_FAST_WAKE;
    logic SLEEP_CORE_LEVEL_LOW;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [1:0] BROWNOUT_CTRL, BROWNOUT_SELECT_FIELD;
    logic [2:0] SLOW_OSC_START_DELAY;
    logic [10:0] outs;
    int fail_count = 0;
    int n_checks = 0;
    pwrax_row_t rows [13];

    // all side outputs packed for one compare
    assign outs = {SLOW_OSC_START_DELAY, SLOW_OSC_REQ, FAST_OSC_TRIM_SELECT, FAST_OSC_POWER_OWNER,
        BROWNOUT_SELECT_FIELD, FLASH_DEEP_STANDBY, FLASH_FAST_WAKE, SLEEP_CORE_LEVEL_LOW};

    pwrax_regs #(.SLOW_OSC_DELAY_STEP(1)) dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .RUN_MODE(RUN_MODE), .DEEP_SLEEP(DEEP_SLEEP),
        .POWER_DOWN(POWER_DOWN), .SYSTEM_RESET(SYSTEM_RESET), .BROWNOUT_CTRL(BROWNOUT_CTRL),
        .SLOW_OSC_START_DELAY(SLOW_OSC_START_DELAY), .SLOW_OSC_REQ(SLOW_OSC_REQ),
        .FAST_OSC_TRIM_SELECT(FAST_OSC_TRIM_SELECT), .FAST_OSC_POWER_OWNER(FAST_OSC_POWER_OWNER),
        .BROWNOUT_SELECT_FIELD(BROWNOUT_SELECT_FIELD), .FLASH_DEEP_STANDBY(FLASH_DEEP_STANDBY),
        .FLASH_FAST_WAKE(FLASH_FAST_WAKE), .SLEEP_CORE_LEVEL_LOW(SLEEP_CORE_LEVEL_LOW));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask : tick

    // entered just after an edge; one idle cycle after each transfer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'h1;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (PREADY !== 1'h1 && n < 20);
        if (n >= 20) fail_count++;
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge SYS_CLK);
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    initial begin
        SYS_CLK = 1'h0;
        forever #50 SYS_CLK = ~SYS_CLK;
    end

    // the whole run needs well under 2000 cycles
    initial begin
        tick(20000);
        fail_count++;
        give_verdict();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {NRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {RUN_MODE, DEEP_SLEEP, POWER_DOWN, SYSTEM_RESET} = '0;
        BROWNOUT_CTRL = 2'h2;
        rows = '{'{1'h0, 8'h14, 32'h00001EEF, 32'h00001EEF, 1'h0},
            '{1'h0, 8'h14, 32'h0000084F, 32'h0000084F, 1'h0},
            '{1'h0, 8'h14, 32'h0000080F, 32'h0000084F, 1'h0},
            '{1'h0, 8'h14, 32'h0000082F, 32'h0000082F, 1'h0},
            '{1'h0, 8'h14, 32'h0000080F, 32'h0000080F, 1'h0},
            '{1'h0, 8'h14, 32'h0000084F, 32'h0000080F, 1'h0},
            '{1'h0, 8'h14, 32'h00000EAF, 32'h00000EAF, 1'h0},
            '{1'h0, 8'h28, 32'h0000000C, 32'h0000000C, 1'h0},
            '{1'h0, 8'h24, 32'h0000000C, 32'h0000000C, 1'h0},
            '{1'h1, 8'h20, 32'h00000003, 32'h00000007, 1'h0},
            '{1'h0, 8'h20, 32'h00000000, 32'h00000007, 1'h0},
            '{1'h1, 8'h20, 32'h00000000, 32'h00000004, 1'h0},
            '{1'h0, 8'h30, 32'hFFFFFFFF, 32'h00000000, 1'h1}};
        tick(10);
        NRST <= 1'h1;
        tick(1);
        rdchk(OFF_OSC_CFG, RST_OSC_CFG);
        rdchk(OFF_FLASH_CTL, RST_FLASH_CTL);
        rdchk(OFF_SLP_LEVEL, RST_SLP_LEVEL);
        rdchk(OFF_SLP_ENABLE, RST_SLP_ENABLE);
        chk({21'h0, outs}, 32'h3B0);
        $display("done reset values");
        RUN_MODE <= 1'h1;
        tick(4);
        foreach (rows[i]) begin
            if (rows[i].k) apb(1'h1, OFF_FLASH_CTL, FLASH_UNLOCK_KEY);
            apb(1'h1, rows[i].a, rows[i].d);
            chk({31'h0, er}, {31'h0, rows[i].e});
            rdchk(rows[i].a, rows[i].r);
        end
        chk({21'h0, outs}, 32'h3B1);
        $display("done table");
        apb(1'h1, OFF_FLASH_CTL, FLASH_UNLOCK_KEY);
        apb(1'h1, OFF_FLASH_CTL, 32'h3);
        tick(1);
        chk({21'h0, outs}, 32'h3B7);
        DEEP_SLEEP <= 1'h1;
        tick(6);
        chk({21'h0, outs}, 32'h333);
        DEEP_SLEEP <= 1'h0;
        tick(20);
        chk({21'h0, outs}, 32'h3B3);
        apb(1'h1, OFF_OSC_CFG, 32'hE2F);
        DEEP_SLEEP <= 1'h1;
        tick(6);
        chk({21'h0, outs}, 32'h3B3);
        DEEP_SLEEP <= 1'h0;
        apb(1'h1, OFF_FLASH_CTL, FLASH_UNLOCK_KEY);
        apb(1'h1, OFF_FLASH_CTL, 32'h2);
        chk({31'h0, FLASH_DEEP_STANDBY}, 32'h1);
        POWER_DOWN <= 1'h1;
        tick(6);
        chk({21'h0, outs}, 32'h3B1);
        POWER_DOWN <= 1'h0;
        apb(1'h1, OFF_OSC_CFG, 32'hCAF);
        tick(3);
        chk({21'h0, outs}, 32'h3B9);
        $display("done sleep and brownout");
        apb(1'h1, OFF_OSC_CFG, 32'hEEF);
        SYSTEM_RESET <= 1'h1;
        tick(5);
        SYSTEM_RESET <= 1'h0;
        tick(4);
        rdchk(OFF_OSC_CFG, 32'hEEF);
        rdchk(OFF_SLP_LEVEL, 32'hC);
        chk({21'h0, outs}, 32'h3F1);
        apb(1'h1, OFF_SLP_ENABLE, 32'h0);
        tick(2);
        chk({21'h0, outs}, 32'h3F0);
        NRST <= 1'h0;
        tick(2);
        NRST <= 1'h1;
        tick(1);
        rdchk(OFF_SLP_LEVEL, RST_SLP_LEVEL);
        $display("done system reset");
        give_verdict();
    end
endmodule : test_pwrax_regs

`default_nettype wire
